/* File: bps_pkg.sv */
// Purpose: shared constants and types of the protection supervisor
// Assumes: 250 MHz hclk, AHB-Lite register access
// Notes:   offsets are byte addresses, one word per register
package bps_pkg;
    localparam int NPRIM       = 19;
    localparam int NPF         = 22;
    localparam int AW          = 12;
    localparam int TICKW       = 28;
    localparam int CLK_MHZ     = 250;
    localparam int EVAL_MS     = 1000;
    localparam int EVAL_CYCLES = EVAL_MS * 1000 * CLK_MHZ;

    localparam logic [AW-1:0] OFF_PROT_EN   = 12'h000;
    localparam logic [AW-1:0] OFF_PROT_AUTO = 12'h004;
    localparam logic [AW-1:0] OFF_CTRL      = 12'h008;
    localparam logic [AW-1:0] OFF_PF_EN     = 12'h00C;
    localparam logic [AW-1:0] OFF_STATUS    = 12'h010;
    localparam logic [AW-1:0] OFF_PF_ALERT  = 12'h014;
    localparam logic [AW-1:0] OFF_PF_TRIP   = 12'h018;
    localparam logic [AW-1:0] OFF_PRIM_ACT  = 12'h01C;
    localparam logic [AW-1:0] OFF_PF_CFG0   = 12'h040;

    // primary index: 0 cuv 1 cov 2 cov latch 3 occ 4..6 ocd 7 ocd latch
    // 8 scd 9 scd latch 10 utc 11 utd 12 utint 13 otc 14 otd 15 otint
    // 16 fet ot 17 precharge timeout 18 host watchdog
    localparam logic [NPRIM-1:0] PRIM_HW_MASK  = 19'h0_013B;
    localparam logic [NPRIM-1:0] PRIM_CHG_MASK = 19'h7_B40E;
    localparam logic [NPRIM-1:0] PRIM_DSG_MASK = 19'h5_DBF1;
    localparam logic [NPRIM-1:0] PROT_EN_RST   = 19'h7_FFFF;
    localparam logic [NPRIM-1:0] PROT_AUTO_RST = 19'h7_FFFF;
    localparam logic [NPF-1:0]   PF_EN_RST     = 22'h00_0000;

    // permanent-fail check index
    localparam int PF_IDX_SLP = 10;
    localparam int PF_IDX_CMD = 20;

    localparam int ST_PF       = 0;
    localparam int ST_CHG      = 1;
    localparam int ST_DSG      = 2;
    localparam int ST_FUSE     = 3;
    localparam int ST_OTP_PEND = 4;
    localparam int ST_SLEEP    = 5;
    localparam int ST_FUSE_OK  = 6;

    typedef enum logic [1:0] {STY_AUTO, STY_HOST_REC, STY_ALERT} bps_style_t;
    typedef enum logic [1:0] {PFA_FLAG, PFA_FETS_OFF, PFA_FUSE} bps_pfact_t;

    typedef struct packed {
        logic       cmd_pf;
        logic       ldo2_on;
        logic       ldo1_on;
        logic       ldo_off_en;
        logic       sleep_en;
        logic       otp_en;
        bps_pfact_t pf_action;
        logic       release_hold;
        bps_style_t style;
        logic       dsg_on;
        logic       chg_on;
    } bps_ctrl_t;
    localparam bps_ctrl_t CTRL_RST = 13'h0C03;

    typedef struct packed {
        logic [3:0] dly;
        logic [7:0] thr;
    } bps_pfcfg_t;
    localparam bps_pfcfg_t PF_CFG_RST = 12'h2FF;
    localparam logic [3:0] DLY_MAX    = 4'hF;
endpackage : bps_pkg

/* File: bps_supervisor.sv */
// Purpose: primary fet control and permanent-fail supervision
// Assumes: single 250 MHz clock, AHB-Lite slave, zero wait states
// Notes:   measurements arrive already scaled to 8-bit codes
//
// What this block does
// [R1] each primary protection enabled separately
// [R2] per-protection choice of autonomous fet control
// [R3] comparator faults vs firmware faults by source
// [R4] three styles: auto, host recovery, alert only
// [R5] fet gates follow host command and protections
// [R6] permanent fail: flag, fets off, or fuse
// [R7] sensed fuse pin feeds a fail check
// [R8] per-check enable, threshold and delay
// [R9] fail status volatile, optionally recorded to otp
// [R10] otp write deferred while low supply/hot
// [R11] deep sleep after fail, after fuse/otp done
// [R12] ldos off on fail if set, host re-enables
// [R13] first detection sets readable alert and pin
// [R14] fail checks evaluated once per second only
// [R15] alert cleared only by a periodic evaluation or by disabling its check
// [R16] no further action after permanent fail
// [R17] fail sources listed by check index
// [R18] fail declared after delay of persisting alert
`timescale 1ns/1ns
module bps_supervisor
    import bps_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = EVAL_CYCLES
) (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    input  wire logic [NPRIM-1:0]      prim_cmp_fault,
    input  wire logic [NPRIM-1:0]      prim_fw_fault,
    input  wire logic [NPF-1:0][7:0]   pf_meas,
    input  wire logic                  fuse_i,
    output logic                       fuse_o,
    output logic                       fuse_oe,
    input  wire logic                  otp_inhibit,
    input  wire logic                  otp_done,
    output logic                       otp_prog_o,
    output logic                       charge_path_fet_o,
    output logic                       discharge_path_fet_o,
    output logic                       first_aux_ldo_o,
    output logic                       second_aux_ldo_o,
    output logic                       lowest_power_state_o,
    output logic                       alert_o
);
    // ****************************************
    // bus slave and registers
    // ****************************************
    logic [NPRIM-1:0] prot_en_q, prot_en_d, prot_auto_q, prot_auto_d;
    logic [NPF-1:0]   pf_en_q, pf_en_d;
    bps_ctrl_t        ctrl_q, ctrl_d;
    bps_pfcfg_t       pf_cfg_q [NPF];
    bps_pfcfg_t       pf_cfg_d [NPF];
    logic             wr_q, wr_d;
    logic [AW-1:0]    waddr_q, waddr_d;
    logic [31:0]      rdata_q, rdata_d;
    logic [NPF-1:0]   alert_q, trip_q;
    logic [NPRIM-1:0] prim_act;
    logic             pf_q, pf_d, otp_pend_q, fuse_q, fuse_ok_q, sleep_q;
    logic             chg_q, dsg_q;
    logic [31:0]      status;
    logic             addr_ph;
    logic [AW-1:0]    cfg_off;

    assign addr_ph = hsel & hready & htrans[1];
    assign cfg_off = haddr[AW-1:0] - OFF_PF_CFG0;
    assign status  = {25'h000_0000, fuse_ok_q, sleep_q, otp_pend_q, fuse_q,
                      dsg_q, chg_q, pf_q};

    always_comb begin
        logic [AW-1:0] woff;
        woff        = waddr_q - OFF_PF_CFG0;
        prot_en_d   = prot_en_q;
        prot_auto_d = prot_auto_q;
        pf_en_d     = pf_en_q;
        ctrl_d      = ctrl_q;
        ctrl_d.release_hold = 1'b0;
        pf_cfg_d    = pf_cfg_q;
        wr_d        = addr_ph & hwrite;
        waddr_d     = addr_ph ? haddr[AW-1:0] : waddr_q;
        rdata_d     = 32'h0000_0000;
        if (wr_q) begin
            unique case (waddr_q)
                OFF_PROT_EN:   prot_en_d   = hwdata[NPRIM-1:0]; // R1
                OFF_PROT_AUTO: prot_auto_d = hwdata[NPRIM-1:0]; // R2
                OFF_CTRL:      ctrl_d      = bps_ctrl_t'(hwdata[12:0]);
                OFF_PF_EN:     pf_en_d     = hwdata[NPF-1:0]; // R8
                default: begin
                    if (waddr_q >= OFF_PF_CFG0 && woff[AW-1:2] < AW'(NPF))
                        pf_cfg_d[woff[6:2]] = bps_pfcfg_t'(hwdata[11:0]); // R8
                end
            endcase
        end
        if (pf_d && !pf_q && ctrl_q.ldo_off_en) begin
            ctrl_d.ldo1_on = 1'b0; // R12
            ctrl_d.ldo2_on = 1'b0; // R12
        end
        if (addr_ph && !hwrite) begin
            unique case (haddr[AW-1:0])
                OFF_PROT_EN:   rdata_d = 32'(prot_en_q);
                OFF_PROT_AUTO: rdata_d = 32'(prot_auto_q);
                OFF_CTRL:      rdata_d = 32'(ctrl_q);
                OFF_PF_EN:     rdata_d = 32'(pf_en_q);
                OFF_STATUS:    rdata_d = status;
                OFF_PF_ALERT:  rdata_d = 32'(alert_q); // R13
                OFF_PF_TRIP:   rdata_d = 32'(trip_q);
                OFF_PRIM_ACT:  rdata_d = 32'(prim_act);
                default: begin
                    if (haddr[AW-1:0] >= OFF_PF_CFG0 && cfg_off[AW-1:2] < AW'(NPF))
                        rdata_d = 32'(pf_cfg_q[cfg_off[6:2]]);
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prot_en_q   <= PROT_EN_RST;
            prot_auto_q <= PROT_AUTO_RST;
            pf_en_q     <= PF_EN_RST;
            ctrl_q      <= CTRL_RST;
            wr_q        <= 1'b0;
            waddr_q     <= '0;
            rdata_q     <= 32'h0000_0000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            for (int i = 0; i < NPF; i++) pf_cfg_q[i] <= PF_CFG_RST;
        end else begin
            prot_en_q   <= prot_en_d;
            prot_auto_q <= prot_auto_d;
            pf_en_q     <= pf_en_d;
            ctrl_q      <= ctrl_d;
            wr_q        <= wr_d;
            waddr_q     <= waddr_d;
            rdata_q     <= rdata_d;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            pf_cfg_q    <= pf_cfg_d;
        end
    end
    assign hrdata = rdata_q;

    // ****************************************
    // primary protections and fet drive
    // ****************************************
    logic [NPRIM-1:0] hold_q, hold_d, auto_f, block;
    logic             chg_d, dsg_d, pf_fets_off;

    assign prim_act = ((prim_cmp_fault & PRIM_HW_MASK) // R3
                     | (prim_fw_fault & ~PRIM_HW_MASK)) & prot_en_q; // R1
    assign auto_f   = prim_act & prot_auto_q; // R2
    assign pf_fets_off = pf_q && ctrl_q.pf_action != PFA_FLAG;

    always_comb begin
        hold_d = '0;
        block  = '0;
        unique case (ctrl_q.style)
            STY_AUTO:     block = auto_f; // R4
            STY_HOST_REC: begin
                hold_d = auto_f | (hold_q & ~{NPRIM{ctrl_q.release_hold}}); // R4
                block  = hold_q | auto_f;
            end
            default:      block = '0; // R4
        endcase
        chg_d = ctrl_q.chg_on && !(|(block & PRIM_CHG_MASK)) && !pf_fets_off; // R5
        dsg_d = ctrl_q.dsg_on && !(|(block & PRIM_DSG_MASK)) && !pf_fets_off; // R5
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_q <= '0;
            chg_q  <= 1'b0;
            dsg_q  <= 1'b0;
        end else begin
            hold_q <= hold_d;
            chg_q  <= chg_d;
            dsg_q  <= dsg_d;
        end
    end
    assign charge_path_fet_o    = chg_q;
    assign discharge_path_fet_o = dsg_q;

    // ****************************************
    // permanent-fail evaluation
    // ****************************************
    logic [TICKW-1:0] tick_cnt_q, tick_cnt_d;
    logic             tick_q, tick_d, eval;
    logic [NPF-1:0]   cond, alert_d, trip_d;
    logic [3:0]       cnt_q [NPF];
    logic [3:0]       cnt_d [NPF];

    always_comb begin
        tick_d     = tick_cnt_q == TICKW'(TICK_CYCLES - 1);
        tick_cnt_d = tick_d ? '0 : tick_cnt_q + 1'b1; // R14
    end
    assign eval = tick_q && !pf_q && !sleep_q; // R14 R16

    // check index: 0 cuv 1 cov 2 occ 3 ocd 4 cell ot 5 fet ot 6 copper
    // 7 scd latch 8 imbal active 9 imbal rest 10 second level 11 dsg fet
    // 12 chg fet 13 otp 14 data rom 15 instr rom 16 lfo 17 vref 18 vss
    // 19 mux 20 commanded 21 stack vs cell sum
    for (genvar i = 0; i < NPF; i++) begin : g_pf
        if (i == PF_IDX_SLP) begin : g_slp
            assign cond[i] = pf_en_q[i] & fuse_i & ~fuse_q; // R7
        end else if (i == PF_IDX_CMD) begin : g_cmd
            assign cond[i] = pf_en_q[i] & ctrl_q.cmd_pf; // R17
        end else begin : g_thr
            assign cond[i] = pf_en_q[i] & (pf_meas[i] >= pf_cfg_q[i].thr); // R8 R17
        end
        assign alert_d[i] = eval ? cond[i] : (alert_q[i] & pf_en_q[i]); // R13 R15
        assign cnt_d[i]   = !eval ? cnt_q[i] : !cond[i] ? 4'h0 :
                            (cnt_q[i] == DLY_MAX) ? DLY_MAX : cnt_q[i] + 4'h1;
        assign trip_d[i]  = trip_q[i]
                          | (eval & cond[i] & (cnt_q[i] >= pf_cfg_q[i].dly)); // R18
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
            alert_q    <= '0;
            trip_q     <= '0;
            for (int i = 0; i < NPF; i++) cnt_q[i] <= 4'h0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            tick_q     <= tick_d;
            alert_q    <= alert_d;
            trip_q     <= trip_d;
            cnt_q      <= cnt_d;
        end
    end

    // ****************************************
    // permanent-fail actions
    // ****************************************
    logic pf_rise, otp_pend_d, otp_prog_d, fuse_d, fuse_ok_d, sleep_d;
    logic ldo1_q, ldo2_q, alert_o_q;

    always_comb begin
        pf_d       = pf_q | (|trip_q); // R9
        pf_rise    = pf_d & ~pf_q;
        otp_pend_d = (pf_rise & ctrl_q.otp_en) | (otp_pend_q & ~otp_done); // R9
        otp_prog_d = otp_pend_d & ~otp_inhibit; // R10
        fuse_d     = fuse_q | (pf_rise & (ctrl_q.pf_action == PFA_FUSE)); // R6
        fuse_ok_d  = fuse_ok_q | (fuse_q & fuse_i); // R7
        sleep_d    = sleep_q | (pf_q & ctrl_q.sleep_en & ~otp_pend_q
                   & (~fuse_q | fuse_ok_q)); // R11
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pf_q       <= 1'b0;
            otp_pend_q <= 1'b0;
            otp_prog_o <= 1'b0;
            fuse_q     <= 1'b0;
            fuse_ok_q  <= 1'b0;
            sleep_q    <= 1'b0;
            ldo1_q     <= 1'b0;
            ldo2_q     <= 1'b0;
            alert_o_q  <= 1'b0;
        end else begin
            pf_q       <= pf_d;
            otp_pend_q <= otp_pend_d;
            otp_prog_o <= otp_prog_d;
            fuse_q     <= fuse_d;
            fuse_ok_q  <= fuse_ok_d;
            sleep_q    <= sleep_d;
            ldo1_q     <= ctrl_q.ldo1_on; // R12
            ldo2_q     <= ctrl_q.ldo2_on; // R12
            alert_o_q  <= |alert_q; // R13
        end
    end
    assign fuse_o               = fuse_q;
    assign fuse_oe              = fuse_q;
    assign lowest_power_state_o = sleep_q;
    assign first_aux_ldo_o      = ldo1_q;
    assign second_aux_ldo_o     = ldo2_q;
    assign alert_o              = alert_o_q;

    // ****************************************
    // assertions
    // ****************************************
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_sel;
        ctrl_q.style == STY_AUTO && |(auto_f & PRIM_CHG_MASK) |=> !chg_q;
    endproperty
    a_sel: assert property (p_sel) else $error("auto fault left charge on"); // R2

    property p_style;
        ctrl_q.style == STY_ALERT && ctrl_q.chg_on && !pf_q |=> chg_q;
    endproperty
    a_style: assert property (p_style) else $error("alert style acted"); // R4

    property p_fets;
        pf_q && ctrl_q.pf_action != PFA_FLAG |=> !chg_q && !dsg_q;
    endproperty
    a_fets: assert property (p_fets) else $error("fets on after fail"); // R6

    property p_fuse;
        $rose(pf_q) && ctrl_q.pf_action == PFA_FUSE |-> fuse_oe ##1 fuse_oe;
    endproperty
    a_fuse: assert property (p_fuse) else $error("fuse not driven"); // R6

    property p_otp;
        otp_inhibit ##1 otp_inhibit |-> !otp_prog_o;
    endproperty
    a_otp: assert property (p_otp) else $error("otp programmed when inhibited"); // R10

    property p_sleep;
        sleep_q && !$past(sleep_q) |-> !$past(otp_pend_q) && $past(pf_q);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep before otp done"); // R11

    property p_ldo;
        $rose(pf_q) && $past(ctrl_q.ldo_off_en) && !$past(wr_q)
            |=> !first_aux_ldo_o && !second_aux_ldo_o;
    endproperty
    a_ldo: assert property (p_ldo) else $error("ldos stayed on"); // R12

    property p_alert;
        |alert_q |=> alert_o;
    endproperty
    a_alert: assert property (p_alert) else $error("alert pin missing"); // R13

    property p_eval;
        !tick_q |=> (alert_q & ~$past(alert_q)) == '0;
    endproperty
    a_eval: assert property (p_eval) else $error("alert set off tick"); // R14

    property p_clear;
        |(~alert_q & $past(alert_q) & pf_en_q) |-> $past(tick_q);
    endproperty
    a_clear: assert property (p_clear) else $error("alert cleared off tick"); // R15

    property p_freeze;
        pf_q ##1 1'b1 |-> $stable(alert_q) || (alert_q & ~$past(alert_q)) == '0;
    endproperty
    a_freeze: assert property (p_freeze) else $error("action after fail"); // R16

    property p_dly;
        |(trip_q & ~$past(trip_q)) |-> $past(tick_q);
    endproperty
    a_dly: assert property (p_dly) else $error("trip off evaluation"); // R18
endmodule : bps_supervisor

/* File: bps_host_model.sv */
// Purpose: host processor model, AHB-Lite master of the supervisor
// Assumes: single word transfers, slave answers OKAY
// Notes:   the bench calls xfer; a hung wait raises timed_out
`timescale 1ns/1ns
module bps_host_model
    import bps_pkg::*;
(
    input  wire logic        hclk,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             timed_out
);
    initial begin
        hsel      = 1'b0;
        haddr     = 32'h0000_0000;
        htrans    = 2'b00;
        hwrite    = 1'b0;
        hsize     = 3'b010;
        hwdata    = 32'h0000_0000;
        timed_out = 1'b0;
    end

    // ****************************************
    // one transfer: address phase, then data phase
    // ****************************************
    task automatic xfer(input logic wr, input logic [AW-1:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {20'h0_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        htrans <= 2'b00;
        hwdata <= wd;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        rd = hrdata;
        if (n >= 100) begin
            timed_out = 1'b1;
        end
    endtask : xfer
endmodule : bps_host_model

/* File: test_battery_protection_supervisor.sv */
// Purpose: self-checking bench of the protection supervisor
// Assumes: evaluation tick shortened to 20 cycles
// Notes:   obs packs alert,sleep,otp,fuse_oe,ldo2,ldo1,dsg,chg
`timescale 1ns/1ns
module test_battery_protection_supervisor
    import bps_pkg::*;
;
    logic                hclk, hresetn, hsel, hwrite, hreadyout, hresp, tmo;
    logic [31:0]         haddr, hwdata, hrdata;
    logic [1:0]          htrans;
    logic [2:0]          hsize;
    logic [NPRIM-1:0]    prim_cmp, prim_fw;
    logic [NPF-1:0][7:0] pf_meas;
    logic                fuse_o, fuse_oe, ext_fuse, otp_inh, otp_done, otp_prog;
    logic                charge_path_fet, discharge_path_fet, ldo1, ldo2, sleep, alert;
    int                  errors, n_checks;
    // pin follows ext_fuse unless the supervisor drives it
    wire                 fuse_pin = fuse_oe ? fuse_o : ext_fuse;
    wire [7:0]           obs      = {alert, sleep, otp_prog, fuse_oe, ldo2, ldo1, discharge_path_fet, charge_path_fet};

    bps_host_model host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .timed_out(tmo));

    bps_supervisor #(.TICK_CYCLES(20)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .prim_cmp_fault(prim_cmp), .prim_fw_fault(prim_fw), .pf_meas(pf_meas),
        .fuse_i(fuse_pin), .fuse_o(fuse_o), .fuse_oe(fuse_oe), .otp_inhibit(otp_inh),
        .otp_done(otp_done), .otp_prog_o(otp_prog), .charge_path_fet_o(charge_path_fet),
        .discharge_path_fet_o(discharge_path_fet), .first_aux_ldo_o(ldo1), .second_aux_ldo_o(ldo2),
        .lowest_power_state_o(sleep), .alert_o(alert));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        logic [31:0] r;
        host.xfer(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [AW-1:0] a, input logic [31:0] msk,
                      input logic [31:0] e, input string m);
        logic [31:0] r;
        host.xfer(1'b0, a, 32'h0000_0000, r);
        chk(r & msk, e, m);
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : cyc

    task automatic waitv(input int b, input logic v, input int lim);
        int n;
        n = 0;
        while (obs[b] !== v && n < lim) begin
            @(posedge hclk);
            n++;
        end
        chk({31'h0, obs[b]}, {31'h0, v}, "output wait");
        if (obs[b] !== v) begin
            conclude();
        end
    endtask : waitv

    task automatic do_reset;
        hresetn <= 1'b0;
        cyc(8);
        hresetn <= 1'b1;
        cyc(2);
    endtask : do_reset

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs;
        chk(obs, 8'h0F, "outputs after reset");
        rd(OFF_PROT_EN, 32'hFFFF_FFFF, 32'h0007_FFFF, "prot_en rst");
        rd(OFF_PROT_AUTO, 32'hFFFF_FFFF, 32'h0007_FFFF, "prot_auto rst");
        rd(OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0C03, "ctrl rst");
        rd(OFF_PF_EN, 32'hFFFF_FFFF, 32'h0000_0000, "pf_en rst");
        rd(OFF_PF_CFG0, 32'hFFFF_FFFF, 32'h0000_02FF, "pf cfg rst");
        wr(12'h030, 32'hFFFF_FFFF);
        rd(12'h030, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
        chk({31'h0, hresp}, 32'h0000_0000, "okay response");
    endtask : t_regs

    task automatic t_prim;
        prim_cmp <= 19'h0_0001;
        cyc(3);
        chk(obs, 8'h0D, "uv blocks dsg");
        rd(OFF_PRIM_ACT, 32'hFFFF_FFFF, 32'h0000_0001, "active uv");
        prim_cmp <= 19'h0_2000;
        prim_fw  <= 19'h0_0001;
        cyc(3);
        chk(obs, 8'h0F, "wrong source ignored");
        prim_cmp <= 19'h0_0000;
        prim_fw  <= 19'h0_2000;
        cyc(3);
        chk(obs, 8'h0E, "fw ot blocks chg");
        prim_fw <= 19'h0_0000;
        wr(OFF_PROT_AUTO, 32'h0007_FFFE);
        prim_cmp <= 19'h0_0001;
        cyc(3);
        chk(obs, 8'h0F, "no auto control");
        wr(OFF_PROT_EN, 32'h0007_FFFE);
        rd(OFF_PRIM_ACT, 32'hFFFF_FFFF, 32'h0000_0000, "disabled prot");
        prim_cmp <= 19'h0_0000;
        wr(OFF_PROT_EN, 32'h0007_FFFF);
        wr(OFF_PROT_AUTO, 32'h0007_FFFF);
    endtask : t_prim

    task automatic t_style;
        wr(OFF_CTRL, 32'h0000_0C07);
        prim_cmp <= 19'h0_0001;
        cyc(3);
        prim_cmp <= 19'h0_0000;
        cyc(4);
        chk(obs, 8'h0D, "held until release");
        wr(OFF_CTRL, 32'h0000_0C17);
        cyc(3);
        chk(obs, 8'h0F, "released");
        wr(OFF_CTRL, 32'h0000_0C0B);
        prim_cmp <= 19'h0_0001;
        cyc(3);
        chk(obs, 8'h0F, "alert only");
        prim_cmp <= 19'h0_0000;
        wr(OFF_CTRL, 32'h0000_0C02);
        cyc(3);
        chk(obs, 8'h0E, "host chg off");
        wr(OFF_CTRL, 32'h0000_0C03);
    endtask : t_style

    task automatic t_pf_delay;
        wr(OFF_PF_CFG0, 32'h0000_0280);
        pf_meas[0] <= 8'h90;
        cyc(45);
        chk({31'h0, alert}, 32'h0, "disabled check");
        wr(OFF_PF_EN, 32'h0000_0001);
        waitv(7, 1'b1, 60);
        rd(OFF_STATUS, 32'h0000_0001, 32'h0000_0000, "no early trip");
        pf_meas[0] <= 8'h10;
        cyc(5);
        pf_meas[0] <= 8'h90;
        chk({31'h0, alert}, 32'h1, "alert holds");
        wr(OFF_CTRL, 32'h0000_0E23);
        waitv(1, 1'b0, 60);
        chk(obs, 8'h80, "fets and ldos off");
        pf_meas[0] <= 8'h00;
        cyc(50);
        chk(obs, 8'h80, "no later action");
        wr(OFF_CTRL, 32'h0000_0623);
        cyc(3);
        chk(obs, 8'h84, "host ldo on");
        do_reset();
        rd(OFF_STATUS, 32'h0000_0001, 32'h0000_0000, "pf lost on reset");
        chk(obs, 8'h0F, "fresh after reset");
    endtask : t_pf_delay

    task automatic t_fuse;
        otp_inh <= 1'b1;
        wr(OFF_PF_CFG0 + 12'h050, 32'h0000_0000);
        wr(OFF_PF_EN, 32'h0010_0000);
        wr(OFF_CTRL, 32'h0000_1DC3);
        waitv(4, 1'b1, 60);
        cyc(10);
        chk({29'h0, fuse_o, otp_prog, sleep}, 32'h4, "otp held");
        otp_inh <= 1'b0;
        waitv(5, 1'b1, 10);
        cyc(3);
        chk({31'h0, sleep}, 32'h0, "sleep waits otp");
        otp_done <= 1'b1;
        waitv(6, 1'b1, 10);
        otp_done <= 1'b0;
        rd(OFF_STATUS, 32'h0000_0009, 32'h0000_0009, "pf and fuse");
        do_reset();
    endtask : t_fuse

    task automatic t_sense;
        wr(OFF_PF_CFG0 + 12'h028, 32'h0000_0000);
        wr(OFF_PF_EN, 32'h0000_0400);
        ext_fuse <= 1'b1;
        cyc(60);
        rd(OFF_STATUS, 32'h0000_0001, 32'h0000_0001, "sensed fuse");
        chk({30'h0, obs[1:0]}, 32'h3, "flag only");
        chk({31'h0, fuse_oe}, 32'h0, "not driving");
        ext_fuse <= 1'b0;
        do_reset();
    endtask : t_sense

    // ****************************************
    // clock, hang guard, main sequence
    // ****************************************
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    always @(posedge tmo) begin
        errors++;
        conclude();
    end

    initial begin
        hresetn  = 1'b0;
        prim_cmp = '0;
        prim_fw  = '0;
        pf_meas  = '0;
        ext_fuse = 1'b0;
        otp_inh  = 1'b0;
        otp_done = 1'b0;
        errors   = 0;
        n_checks = 0;
        do_reset();
        t_regs();
        t_prim();
        t_style();
        t_pf_delay();
        t_fuse();
        t_sense();
        conclude();
    end
endmodule : test_battery_protection_supervisor
